//--- logic/lcd_scan_pkg.sv
// constants and types shared by the display ram loader and scanner
package lcd_scan_pkg;

    // drive modes, named by backplane count
    typedef enum logic [1:0] {
        MODE_STATIC = 2'b00,
        MODE_TWO    = 2'b01,
        MODE_THREE  = 2'b10,
        MODE_FOUR   = 2'b11
    } drive_mode_e;

    // ram geometry
    localparam int unsigned ROWS        = 4;
    localparam int unsigned COLUMNS     = 40;
    localparam logic [5:0]  LAST_COLUMN = 6'h27;
    localparam int unsigned BYTE_BITS   = 8;

    // frame timing: one frame is this many device clocks
    localparam int unsigned FRAME_DIV   = 24;
    localparam logic [4:0]  FRAME_LAST  = 5'(FRAME_DIV - 1);

    // counter value loaded when the cascade sync edge is seen
    // (two synchroniser flops plus the edge flop)
    localparam logic [4:0]  SYNC_LATENCY = 5'h03;

    // pointer advance per byte
    localparam logic [3:0]  ADV_STATIC = 4'h8;
    localparam logic [3:0]  ADV_TWO    = 4'h4;
    localparam logic [3:0]  ADV_THREE  = 4'h3;
    localparam logic [3:0]  ADV_FOUR   = 4'h2;

    // values after reset
    localparam logic [5:0]  PTR_RESET    = 6'h00;
    localparam logic [2:0]  SUB_RESET    = 3'h0;
    localparam logic [4:0]  COUNT_RESET  = 5'h00;
    localparam logic [1:0]  ROW_RESET    = 2'h0;
    localparam logic [39:0] RAM_RESET    = 40'h00_0000_0000;

endpackage

//--- logic/lcd_display_ram_loader_scanner.sv
// display ram write path and multiplex scan of a 40 x 4 lcd driver
// Contract
// [R1] frame rate is device clock over 24
// [R2] cascade sync edge realigns multiplex timing
// [R3] three-backplane mode: backplane 3 copies 1
// [R4] two-backplane mode: 0 equals 2, 1 equals 3
// [R5] static mode: all backplanes identical
// [R6] forty segment outputs follow scanned row
// [R7] ram one means element on
// [R8] rows map to backplanes, columns to segments
// [R9] static: byte fills row 0, eight columns
// [R10] two mode: four two-bit words, rows 0-1
// [R11] three mode: three columns, last row-2 bit kept
// [R12] four mode: two four-bit words, rows 0-3
// [R13] msb first into lowest row, then next column
// [R14] pointer load sets start address of bytes
// [R15] pointer advances 8, 4, 3 or 2
// [R16] host reloads pointer after aborted transfer
// [R17] store only when subaddress counter matches strap
// [R18] subaddress command loads subaddress counter
// [R19] mismatch suppresses write, pointer still advances
// [R20] pointer overflow increments subaddress counter
// [R21] handover works mid byte
// [R22] host keeps strap pins stable during access
// [R23] bits past last address dropped, not acknowledged
// [R24] scan rows in sequence per mode
// [R25] six-bit pointer wraps past 39 as overflow
`timescale 1ns/1ps

module lcd_display_ram_loader_scanner (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // configuration from the command decoder
    input  wire logic [1:0]  driveMode,
    // pointer load command
    input  wire logic        ptrLoad,
    input  wire logic [5:0]  ptrValue,
    // subaddress select command
    input  wire logic        subLoad,
    input  wire logic [2:0]  subValue,
    // display data byte from the serial receiver
    input  wire logic        dataValid,
    input  wire logic [7:0]  dataByte,
    output logic             dataAck,
    // strapped subaddress pins
    input  wire logic        strap_subaddr_bit0,
    input  wire logic        strap_subaddr_bit1,
    input  wire logic        strap_subaddr_bit2,
    // cascade synchronisation
    input  wire logic        syncIn,
    output logic             syncOut,
    // frame timing
    output logic             frame_rate,
    // lcd drive, logic level only
    output logic             backplane_out_0,
    output logic             backplane_out_1,
    output logic             backplane_out_2,
    output logic             backplane_out_3,
    output logic [39:0]      segment_outputs
);

    // reset release
    logic        rstMeta_q;
    logic        rstSync_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // pin synchronisers; first flop feeds only the second
    logic [2:0]  strapMeta_q;
    logic [2:0]  strap_q;
    logic        syncMeta_q;
    logic        syncIn_q;
    logic        syncPrev_q;

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            strapMeta_q <= 3'h0;
            strap_q     <= 3'h0;
            syncMeta_q  <= 1'b0;
            syncIn_q    <= 1'b0;
            syncPrev_q  <= 1'b0;
        end else begin
            strapMeta_q <= {strap_subaddr_bit2, strap_subaddr_bit1, strap_subaddr_bit0};
            strap_q     <= strapMeta_q;
            syncMeta_q  <= syncIn;
            syncIn_q    <= syncMeta_q;
            syncPrev_q  <= syncIn_q;
        end
    end

    // helpers
    function automatic logic [3:0] advOf(input logic [1:0] m);
        case (m)
            lcd_scan_pkg::MODE_STATIC: advOf = lcd_scan_pkg::ADV_STATIC;
            lcd_scan_pkg::MODE_TWO:    advOf = lcd_scan_pkg::ADV_TWO;
            lcd_scan_pkg::MODE_THREE:  advOf = lcd_scan_pkg::ADV_THREE;
            default:                   advOf = lcd_scan_pkg::ADV_FOUR;
        endcase
    endfunction

    // row of bit slot k (k = 0 is the msb) within its word
    function automatic logic [1:0] rowOf(input logic [1:0] m, input logic [2:0] k);
        case (m)
            lcd_scan_pkg::MODE_STATIC: rowOf = 2'h0;
            lcd_scan_pkg::MODE_TWO:    rowOf = {1'b0, k[0]};
            lcd_scan_pkg::MODE_THREE:  rowOf = 2'(k % 3'h3);
            default:                   rowOf = k[1:0];
        endcase
    endfunction

    // column offset of bit slot k from the pointer
    function automatic logic [2:0] wordOf(input logic [1:0] m, input logic [2:0] k);
        case (m)
            lcd_scan_pkg::MODE_STATIC: wordOf = k;
            lcd_scan_pkg::MODE_TWO:    wordOf = {1'b0, k[2:1]};
            lcd_scan_pkg::MODE_THREE:  wordOf = 3'(k / 3'h3);
            default:                   wordOf = {2'h0, k[2]};
        endcase
    endfunction

    // scanned row for a frame count; 24 splits evenly for 1 to 4 rows
    function automatic logic [1:0] scanRowOf(input logic [1:0] m, input logic [4:0] c);
        case (m)
            lcd_scan_pkg::MODE_STATIC: scanRowOf = 2'h0;
            lcd_scan_pkg::MODE_TWO:    scanRowOf = 2'(c / 5'(lcd_scan_pkg::FRAME_DIV / 2));
            lcd_scan_pkg::MODE_THREE:  scanRowOf = 2'(c / 5'(lcd_scan_pkg::FRAME_DIV / 3));
            default:                   scanRowOf = 2'(c / 5'(lcd_scan_pkg::FRAME_DIV / 4));
        endcase
    endfunction

    // frame counter
    logic [4:0]  frameCount_q;
    logic        syncEdge;

    assign syncEdge = syncIn_q && !syncPrev_q;

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            frameCount_q <= lcd_scan_pkg::COUNT_RESET;
        end else if (syncEdge) begin
            frameCount_q <= lcd_scan_pkg::SYNC_LATENCY; // [R2]
        end else if (frameCount_q == lcd_scan_pkg::FRAME_LAST) begin
            frameCount_q <= lcd_scan_pkg::COUNT_RESET; // [R1]
        end else begin
            frameCount_q <= frameCount_q + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            frame_rate <= 1'b0;
            syncOut    <= 1'b0;
        end else begin
            frame_rate <= (frameCount_q == lcd_scan_pkg::COUNT_RESET); // [R1]
            syncOut    <= (frameCount_q == lcd_scan_pkg::COUNT_RESET); // [R2]
        end
    end

    // pointer and subaddress counter
    logic [5:0]  ptr_q;
    logic [2:0]  sub_q;
    logic [6:0]  ptrSum;
    logic        overflow;
    logic        matchNow;
    logic        matchNext;
    logic        takeByte;

    assign ptrSum    = {1'b0, ptr_q} + {3'h0, advOf(driveMode)};
    assign overflow  = ptrSum > {1'b0, lcd_scan_pkg::LAST_COLUMN}; // [R25]
    assign matchNow  = (sub_q == strap_q); // [R17]
    assign matchNext = (3'(sub_q + 3'h1) == strap_q); // [R21]
    // a simultaneous pointer load wins and drops the byte
    assign takeByte  = dataValid && !ptrLoad;

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ptr_q <= lcd_scan_pkg::PTR_RESET;
        end else if (ptrLoad) begin
            ptr_q <= ptrValue; // [R14]
        end else if (takeByte) begin
            ptr_q <= overflow ? 6'(ptrSum - 7'(lcd_scan_pkg::COLUMNS)) : ptrSum[5:0]; // [R15] [R19] [R25]
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            sub_q <= lcd_scan_pkg::SUB_RESET;
        end else if (subLoad) begin
            sub_q <= subValue; // [R18]
        end else if (takeByte && overflow) begin
            sub_q <= sub_q + 3'h1; // [R20]
        end
    end

    // display ram, one 40-bit vector per row
    logic [39:0] ram_q [lcd_scan_pkg::ROWS];
    logic        storeAny;
    logic [6:0]  bitCol [lcd_scan_pkg::BYTE_BITS];
    logic [1:0]  bitRow [lcd_scan_pkg::BYTE_BITS];

    // each bit chooses its own device, so a wrap mid byte splits cleanly
    always_comb begin
        storeAny = 1'b0;
        for (int k = 0; k < lcd_scan_pkg::BYTE_BITS; k++) begin
            bitCol[k] = 7'(ptr_q) + 7'(wordOf(driveMode, 3'(k)));
            bitRow[k] = rowOf(driveMode, 3'(k)); // [R13]
            if (bitCol[k] > 7'(lcd_scan_pkg::LAST_COLUMN)) begin
                storeAny = storeAny || matchNext; // [R21] [R23]
            end else begin
                storeAny = storeAny || matchNow; // [R17]
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            for (int r = 0; r < lcd_scan_pkg::ROWS; r++) begin
                ram_q[r] <= lcd_scan_pkg::RAM_RESET;
            end
        end else if (takeByte) begin
            for (int k = 0; k < lcd_scan_pkg::BYTE_BITS; k++) begin
                // [R9] [R10] [R11] [R12] [R13] msb goes to the lowest row first
                if (bitCol[k] > 7'(lcd_scan_pkg::LAST_COLUMN)) begin
                    if (matchNext) begin
                        ram_q[bitRow[k]][6'(bitCol[k] - 7'(lcd_scan_pkg::COLUMNS))] <= dataByte[7 - k]; // [R21] [R25]
                    end
                end else if (matchNow) begin
                    ram_q[bitRow[k]][bitCol[k][5:0]] <= dataByte[7 - k]; // [R7] [R17] [R19]
                end
            end
        end
    end

    // acknowledge only when some bit landed here
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            dataAck <= 1'b0;
        end else begin
            dataAck <= takeByte && storeAny; // [R23]
        end
    end

    // scan
    logic [1:0]  scanRow;

    assign scanRow = scanRowOf(driveMode, frameCount_q); // [R24]

    // backplane outputs show which slot is active; analog levels are outside
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            backplane_out_0 <= 1'b0;
            backplane_out_1 <= 1'b0;
            backplane_out_2 <= 1'b0;
            backplane_out_3 <= 1'b0;
        end else begin
            case (driveMode)
                lcd_scan_pkg::MODE_STATIC: begin
                    backplane_out_0 <= 1'b1; // [R5]
                    backplane_out_1 <= 1'b1;
                    backplane_out_2 <= 1'b1;
                    backplane_out_3 <= 1'b1;
                end
                lcd_scan_pkg::MODE_TWO: begin
                    backplane_out_0 <= (scanRow == 2'h0); // [R4]
                    backplane_out_1 <= (scanRow == 2'h1);
                    backplane_out_2 <= (scanRow == 2'h0);
                    backplane_out_3 <= (scanRow == 2'h1);
                end
                lcd_scan_pkg::MODE_THREE: begin
                    backplane_out_0 <= (scanRow == 2'h0); // [R3]
                    backplane_out_1 <= (scanRow == 2'h1);
                    backplane_out_2 <= (scanRow == 2'h2);
                    backplane_out_3 <= (scanRow == 2'h1);
                end
                default: begin
                    backplane_out_0 <= (scanRow == 2'h0); // [R8]
                    backplane_out_1 <= (scanRow == 2'h1);
                    backplane_out_2 <= (scanRow == 2'h2);
                    backplane_out_3 <= (scanRow == 2'h3);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            segment_outputs <= lcd_scan_pkg::RAM_RESET;
        end else begin
            segment_outputs <= ram_q[scanRow]; // [R6] [R7] [R8]
        end
    end

    // checks
    chk_frame_period: assert property (@(posedge clk) disable iff (!rstSync_q) // [R1]
        (!syncEdge ##1 (frame_rate && !syncEdge) ##1 (!syncEdge)[*8] ##1 (!syncEdge)[*8] ##1 (!syncEdge)[*6])
            |-> ##2 frame_rate)
        else $error("frame tick spacing is not 24 clocks");

    chk_sync_align: assert property (@(posedge clk) disable iff (!rstSync_q) // [R2]
        syncEdge |=> frameCount_q == lcd_scan_pkg::SYNC_LATENCY)
        else $error("sync edge did not realign the frame");

    chk_three_dup: assert property (@(posedge clk) disable iff (!rstSync_q) // [R3]
        driveMode == lcd_scan_pkg::MODE_THREE |=> backplane_out_3 == backplane_out_1)
        else $error("backplane 3 differs from 1 in three mode");

    chk_two_dup: assert property (@(posedge clk) disable iff (!rstSync_q) // [R4]
        driveMode == lcd_scan_pkg::MODE_TWO |=> backplane_out_0 == backplane_out_2 &&
            backplane_out_1 == backplane_out_3 && backplane_out_0 != backplane_out_1)
        else $error("two mode backplane pairs wrong");

    chk_static_same: assert property (@(posedge clk) disable iff (!rstSync_q) // [R5]
        driveMode == lcd_scan_pkg::MODE_STATIC |=> backplane_out_0 && backplane_out_1 &&
            backplane_out_2 && backplane_out_3)
        else $error("static backplanes differ");

    chk_ptr_advance: assert property (@(posedge clk) disable iff (!rstSync_q) // [R15]
        takeByte && !overflow |=> ptr_q == 6'($past(ptrSum)))
        else $error("pointer advance wrong");

    chk_sub_overflow: assert property (@(posedge clk) disable iff (!rstSync_q) // [R20]
        takeByte && overflow && !subLoad |=> sub_q == 3'($past(sub_q) + 3'h1))
        else $error("overflow did not bump subaddress");

    chk_no_store_ack: assert property (@(posedge clk) disable iff (!rstSync_q) // [R23]
        takeByte && !matchNow && !(overflow && matchNext) |=> !dataAck)
        else $error("byte acknowledged without a match");

    chk_sub_load: assert property (@(posedge clk) disable iff (!rstSync_q) // [R18]
        subLoad |=> sub_q == $past(subValue))
        else $error("subaddress load lost");

    chk_static_row: assert property (@(posedge clk) disable iff (!rstSync_q) // [R24]
        driveMode == lcd_scan_pkg::MODE_STATIC |-> scanRow == 2'h0)
        else $error("static mode scans a row other than 0");

    cov_wrap_split: cover property (@(posedge clk) disable iff (!rstSync_q)
        takeByte && overflow && matchNow);
    cov_three_write: cover property (@(posedge clk) disable iff (!rstSync_q)
        takeByte && driveMode == lcd_scan_pkg::MODE_THREE && matchNow);
    cov_sync_seen: cover property (@(posedge clk) disable iff (!rstSync_q) syncEdge);
    cov_handover: cover property (@(posedge clk) disable iff (!rstSync_q)
        takeByte && overflow && matchNext);

endmodule // lcd_display_ram_loader_scanner

//--- testbench/host_model.sv
// host side model that issues pointer, subaddress and byte requests
`timescale 1ns/1ps

module host_model (
    // clock
    input  wire logic       clk,
    // requests
    output logic            ptrLoad,
    output logic [5:0]      ptrValue,
    output logic            subLoad,
    output logic [2:0]      subValue,
    output logic            dataValid,
    output logic [7:0]      dataByte,
    // answer
    input  wire logic       dataAck
);
    int ackCount = 0;

    initial begin
        ptrLoad   = 1'b0;
        ptrValue  = 6'h00;
        subLoad   = 1'b0;
        subValue  = 3'h0;
        dataValid = 1'b0;
        dataByte  = 8'h00;
    end

    // counted off the edge so a registered ack is settled
    always @(negedge clk) begin
        if (dataAck === 1'b1)
            ackCount++;
    end

    // each fill sequence loads a fresh pointer before its bytes
    task automatic load_ptr(input logic [5:0] v);
        @(negedge clk);
        ptrLoad  = 1'b1;
        ptrValue = v;
        @(negedge clk);
        ptrLoad  = 1'b0;
        ptrValue = ~v;
    endtask

    task automatic load_sub(input logic [2:0] v);
        @(negedge clk);
        subLoad  = 1'b1;
        subValue = v;
        @(negedge clk);
        subLoad  = 1'b0;
        subValue = ~v;
    endtask

    // consecutive calls keep valid high, giving back-to-back bytes
    task automatic send_byte(input logic [7:0] b);
        @(negedge clk);
        dataValid = 1'b1;
        dataByte  = b;
    endtask

    task automatic end_bytes();
        @(negedge clk);
        dataValid = 1'b0;
        dataByte  = ~dataByte;
        repeat (3) @(negedge clk);
    endtask
endmodule // host_model

//--- testbench/lcd_display_ram_loader_scanner_test.sv
// self-checking bench for the display ram loader and scanner
`timescale 1ns/1ps

module lcd_display_ram_loader_scanner_test;
    localparam logic [2:0] STRAP = 3'h5;
    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic [1:0]  driveMode = 2'h3;
    logic        syncIn    = 1'b0;
    logic        ptrLoad, subLoad, dataValid, dataAck, syncOut, frame_rate;
    logic [5:0]  ptrValue;
    logic [2:0]  subValue;
    logic [7:0]  dataByte;
    wire  [3:0]  bp;
    logic [39:0] segs;
    logic [39:0] expRam [4] = '{default: 40'h0};
    logic [5:0]  expPtr;
    logic [2:0]  expSub;
    int          expAck;
    int          failures = 0;
    int          compares = 0;

    always #2.5 clk = ~clk;

    // strap pins stay fixed for the whole run
    lcd_display_ram_loader_scanner lcd_display_ram_loader_scanner_inst (
        .clk(clk), .rst_b(rst_b), .driveMode(driveMode),
        .ptrLoad(ptrLoad), .ptrValue(ptrValue), .subLoad(subLoad), .subValue(subValue),
        .dataValid(dataValid), .dataByte(dataByte), .dataAck(dataAck),
        .strap_subaddr_bit0(STRAP[0]), .strap_subaddr_bit1(STRAP[1]), .strap_subaddr_bit2(STRAP[2]),
        .syncIn(syncIn), .syncOut(syncOut), .frame_rate(frame_rate),
        .backplane_out_0(bp[0]), .backplane_out_1(bp[1]), .backplane_out_2(bp[2]),
        .backplane_out_3(bp[3]), .segment_outputs(segs));

    host_model host_model_inst (
        .clk(clk), .ptrLoad(ptrLoad), .ptrValue(ptrValue), .subLoad(subLoad), .subValue(subValue),
        .dataValid(dataValid), .dataByte(dataByte), .dataAck(dataAck));

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // reference placement of one byte; n is rows used per column
    task automatic model_byte(input int n, input logic [7:0] b);
        int   col;
        logic st;
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 8; k++) begin
            col = int'(expPtr) + k / n;
            st  = (expSub == STRAP);
            if (col > 39) begin
                col -= 40;
                st = (3'(expSub + 3'h1) == STRAP);
            end
            if (st) begin
                expRam[k % n][col] = b[7 - k];
                hit = 1'b1;
            end
        end
        expAck += int'(hit);
        col = int'(expPtr) + ((n == 1) ? 8 : (n == 2) ? 4 : (n == 3) ? 3 : 2);
        if (col > 39) begin
            col -= 40;
            expSub++;
        end
        expPtr = 6'(col);
    endtask

    // four-backplane mode shows every row in turn, so all of ram is visible
    task automatic read_ram();
        int w;
        driveMode = 2'h3;
        repeat (30) @(negedge clk);
        for (int r = 0; r < 4; r++) begin
            w = 0;
            while (bp[r] !== 1'b1 && w < 30) begin
                @(negedge clk);
                w++;
            end
            check("ram row", expRam[r], segs);
        end
    endtask

    task automatic fill(input logic [1:0] m, input logic [2:0] s, input logic [5:0] p,
                        input logic [7:0] b0, input logic [7:0] b1);
        int a0;
        driveMode = m;
        expSub    = s;
        expPtr    = p;
        expAck    = 0;
        host_model_inst.load_sub(s);
        host_model_inst.load_ptr(p);
        a0 = host_model_inst.ackCount;
        host_model_inst.send_byte(b0);
        host_model_inst.send_byte(b1);
        host_model_inst.end_bytes();
        model_byte(int'(m) + 1, b0);
        model_byte(int'(m) + 1, b1);
        check("ack count", 40'(expAck), 40'(host_model_inst.ackCount - a0));
        read_ram();
    endtask

    task automatic t_frame();
        int n;
        n = 0;
        while (frame_rate !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("sync out", 40'(frame_rate), 40'(syncOut));
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (frame_rate !== 1'b1 && n < 40);
        check("frame period", 40'h18, 40'(n));
    endtask

    task automatic sync_gap(input int lead, output int n);
        repeat (lead) @(negedge clk);
        syncIn = 1'b1;
        repeat (2) @(negedge clk);
        syncIn = 1'b0;
        repeat (4) @(negedge clk);
        n = 6;
        while (frame_rate !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
    endtask

    // two different phases must land at the same distance once realigned
    task automatic t_sync();
        int d0;
        int d1;
        sync_gap(3, d0);
        sync_gap(10, d1);
        check("sync realign", 40'(d0), 40'(d1));
        // the load value absorbs the synchroniser delay, so one frame plus one tick
        check("sync delay", 40'(lcd_scan_pkg::FRAME_DIV + 1), 40'(d0));
    endtask

    task automatic t_scan();
        int hi [4];
        int bad;
        for (int m = 0; m < 4; m++) begin
            driveMode = 2'(m);
            repeat (30) @(negedge clk);
            hi  = '{0, 0, 0, 0};
            bad = 0;
            repeat (24) begin
                @(negedge clk);
                for (int r = 0; r < 4; r++)
                    hi[r] += int'(bp[r]);
                if (!((m == 0) ? bp === 4'hf : (m == 1) ? bp inside {4'h5, 4'ha} :
                      (m == 2) ? bp inside {4'h1, 4'ha, 4'h4} : bp inside {4'h1, 4'h2, 4'h4, 4'h8}))
                    bad++;
            end
            check("backplane pattern", 40'h0, 40'(bad));
            for (int r = 0; r < 4; r++)
                check("backplane share", 40'(24 / (m + 1)), 40'(hi[r]));
        end
    endtask

    task automatic t_fills();
        fill(2'h0, STRAP, 6'h00, 8'h96, 8'h3c);
        fill(2'h1, STRAP, 6'h10, 8'h4b, 8'he1);
        fill(2'h3, STRAP, 6'h02, 8'hff, 8'hff);
        fill(2'h2, STRAP, 6'h00, 8'h00, 8'h00);
    endtask

    // wrap into the next device, then last-device drop and a byte after a subaddress-only reload
    task automatic t_cascade();
        int a0;
        fill(2'h3, 3'h4, 6'h27, 8'ha5, 8'h3c);
        fill(2'h3, STRAP, 6'h27, 8'h5a, 8'hc3);
        expAck = 0;
        expSub = STRAP;
        host_model_inst.load_sub(STRAP);
        a0 = host_model_inst.ackCount;
        host_model_inst.send_byte(8'h99);
        host_model_inst.end_bytes();
        model_byte(4, 8'h99);
        check("ack count", 40'(expAck), 40'(host_model_inst.ackCount - a0));
        read_ram();
    endtask

    initial begin
        repeat (2) @(negedge clk);
        check("reset segments", 40'h0, segs);
        check("reset flags", 40'h0, 40'({bp, frame_rate, syncOut, dataAck}));
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_frame();
        t_sync();
        t_scan();
        t_fills();
        t_cascade();
        end_sim();
    end

    // whole run is under a thousand cycles; the 10000-cycle limit leaves a wide margin
    initial begin
        #50000;
        failures++;
        end_sim();
    end
endmodule // lcd_display_ram_loader_scanner_test
